// [rtl/bscan_pkg.sv]
// Purpose: Shared constants and types for the dual-lane transceiver with boundary scan
// Assumes: One 250 MHz core clock samples every pin, the test clock included
// Notes:   Boundary cell positions count from the test-data-out end
package bscan_pkg;

  localparam int LANE_W    = 9;
  localparam int NUM_LANES = 2;
  localparam int PIN_W     = 18;
  localparam int IR_W      = 8;
  localparam int BSR_W     = 80;

  localparam logic [7:0] IR_EXTEST     = 8'h00;
  localparam logic [7:0] IR_SAMPLE     = 8'h81;
  localparam logic [7:0] IR_CLAMP      = 8'h82;
  localparam logic [7:0] IR_HIGHZ      = 8'h03;
  localparam logic [7:0] IR_RESET_CODE = 8'hFF;
  localparam logic [1:0] IR_CAPTURE_LSB = 2'h1;
  // Arbitrary value, not tied to any real part
  localparam logic [5:0] IR_CAPTURE_HI_DEF = 6'h2A;

  // Control group, lane l sits four cells lower per lane
  localparam int BIT_DIR     = 79;
  localparam int BIT_ENN     = 78;
  localparam int BIT_AOE     = 77;
  localparam int BIT_BOE     = 76;
  localparam int CTRL_STRIDE = 4;
  localparam int BIT_AIN_TOP  = 71;
  localparam int BIT_BOUT_TOP = 53;
  localparam int BIT_BIN_TOP  = 35;
  localparam int BIT_AOUT_TOP = 17;

  // Layout of the synchronised pin bundle
  localparam int SY_TCK = 0;
  localparam int SY_TMS = 1;
  localparam int SY_TDI = 2;
  localparam int SY_DIR = 3;
  localparam int SY_ENN = 5;
  localparam int SY_A   = 7;
  localparam int SY_B   = 25;
  localparam int SYNC_W = 43;
  localparam logic [SYNC_W-1:0] SYNC_RST = 43'h00000000060;

  typedef enum logic [3:0] {
    TAP_RESET     = 4'hF,
    TAP_IDLE      = 4'hC,
    TAP_SEL_DR    = 4'h7,
    TAP_CAP_DR    = 4'h6,
    TAP_SHIFT_DR  = 4'h2,
    TAP_EXIT1_DR  = 4'h1,
    TAP_PAUSE_DR  = 4'h3,
    TAP_EXIT2_DR  = 4'h0,
    TAP_UPD_DR    = 4'h5,
    TAP_SEL_IR    = 4'h4,
    TAP_CAP_IR    = 4'hE,
    TAP_SHIFT_IR  = 4'hA,
    TAP_EXIT1_IR  = 4'h9,
    TAP_PAUSE_IR  = 4'hB,
    TAP_EXIT2_IR  = 4'h8,
    TAP_UPD_IR    = 4'hD
  } tap_state_t;

  typedef struct packed {
    tap_state_t state;
  } tap_reg_t;

  localparam tap_reg_t TAP_REG_RST = '{state: TAP_RESET};

  typedef struct packed {
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic              tckPrev;
    logic [IR_W-1:0]   irShift;
    logic [IR_W-1:0]   irActive;
    logic              bypass;
    logic [BSR_W-1:0]  bsrShift;
    logic [BSR_W-1:0]  bsrUpd;
    logic              tdo;
    logic              tdoOeN;
    logic [PIN_W-1:0]  aOut;
    logic [PIN_W-1:0]  aOeN;
    logic [PIN_W-1:0]  bOut;
    logic [PIN_W-1:0]  bOeN;
  } core_state_t;

  localparam core_state_t CORE_RST = '{
    sync1: SYNC_RST, sync2: SYNC_RST, tckPrev: 1'b0,
    irShift: 8'h00, irActive: IR_RESET_CODE, bypass: 1'b0,
    bsrShift: 80'h0, bsrUpd: 80'h0, tdo: 1'b0, tdoOeN: 1'b1,
    aOut: 18'h00000, aOeN: 18'h3FFFF, bOut: 18'h00000, bOeN: 18'h3FFFF};

endpackage

// [rtl/tap_if.sv]
// Purpose: Carries test-clock events and controller state between core and controller
// Assumes: Both ends run on mclk
// Notes:   tckRise is a one-cycle pulse
`timescale 1ns/1ps
interface tap_if;
  import bscan_pkg::*;
  logic       tckRise;
  logic       tms;
  tap_state_t state;
  modport fsm  (input tckRise, input tms, output state);
  modport core (output tckRise, output tms, input state);
endinterface

// [rtl/tap_fsm.sv]
// Purpose: Sixteen-state test access port controller
// Assumes: tckRise and tms already synchronised to mclk
// Notes:   Advances only on a test-clock rising edge pulse
`timescale 1ns/1ps
module tap_fsm
  import bscan_pkg::*;
(
  // Clock and reset
  input  logic mclk,
  input  logic nrst,
  // Controller link
  tap_if.fsm   tap
);

  tap_reg_t r;
  tap_reg_t n;

  function automatic tap_state_t nextTap(input tap_state_t s, input logic m);
    unique case (s)
      TAP_RESET:    nextTap = m ? TAP_RESET    : TAP_IDLE;
      TAP_IDLE:     nextTap = m ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_DR:   nextTap = m ? TAP_SEL_IR   : TAP_CAP_DR;
      TAP_CAP_DR:   nextTap = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: nextTap = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: nextTap = m ? TAP_UPD_DR   : TAP_PAUSE_DR;
      TAP_PAUSE_DR: nextTap = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: nextTap = m ? TAP_UPD_DR   : TAP_SHIFT_DR;
      TAP_UPD_DR:   nextTap = m ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_IR:   nextTap = m ? TAP_RESET    : TAP_CAP_IR;
      TAP_CAP_IR:   nextTap = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: nextTap = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: nextTap = m ? TAP_UPD_IR   : TAP_PAUSE_IR;
      TAP_PAUSE_IR: nextTap = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: nextTap = m ? TAP_UPD_IR   : TAP_SHIFT_IR;
      TAP_UPD_IR:   nextTap = m ? TAP_SEL_DR   : TAP_IDLE;
    endcase
  endfunction

  always_comb
  begin
    n = r;
    if (tap.tckRise)
    begin
      n.state = nextTap(r.state, tap.tms);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      r <= TAP_REG_RST;
    end
    else
    begin
      r <= n;
    end
  end

  assign tap.state = r.state;

  AST_TAP_RESET_HOLD: assert property (@(posedge mclk) disable iff (!nrst)
    (r.state == TAP_RESET && tap.tckRise && tap.tms) |=> (r.state == TAP_RESET))
    else $error("controller left reset with TMS high");

  AST_TAP_STILL: assert property (@(posedge mclk) disable iff (!nrst)
    !tap.tckRise |=> $stable(r.state))
    else $error("controller moved without a test clock edge");

endmodule

// [rtl/dual_byte_transceiver_boundary_scan.sv]
// Purpose: Two nine-bit bidirectional transceiver lanes wrapped in boundary-scan test logic
// Assumes: All pins asynchronous to mclk; TCK slower than mclk/4
// Notes:   System path has three mclk cycles of latency through the synchronisers and output flops
`timescale 1ns/1ps
module dual_byte_transceiver_boundary_scan
  import bscan_pkg::*;
#(
  parameter logic [5:0] IR_CAPTURE_HI = IR_CAPTURE_HI_DEF
)
(
  // Clock and reset
  input  logic             mclk,
  input  logic             nrst,
  // Lane one controls
  input  logic             laneOneDirectionSelect,
  input  logic             laneOneOutputEnableN,
  // Lane two controls
  input  logic             laneTwoDirectionSelect,
  input  logic             laneTwoOutputEnableN,
  // Lane one A side
  input  logic [LANE_W-1:0] laneOnePortAIn,
  output logic [LANE_W-1:0] laneOnePortAOut,
  output logic [LANE_W-1:0] laneOnePortAOeN,
  // Lane one B side
  input  logic [LANE_W-1:0] laneOnePortBIn,
  output logic [LANE_W-1:0] laneOnePortBOut,
  output logic [LANE_W-1:0] laneOnePortBOeN,
  // Lane two A side
  input  logic [LANE_W-1:0] laneTwoPortAIn,
  output logic [LANE_W-1:0] laneTwoPortAOut,
  output logic [LANE_W-1:0] laneTwoPortAOeN,
  // Lane two B side
  input  logic [LANE_W-1:0] laneTwoPortBIn,
  output logic [LANE_W-1:0] laneTwoPortBOut,
  output logic [LANE_W-1:0] laneTwoPortBOeN,
  // Test access port
  input  logic             tck,
  input  logic             tms,
  input  logic             tdi,
  output logic             tdo,
  output logic             tdoOeN
);

  core_state_t        r;
  core_state_t        n;
  tap_if              tap ();

  logic [SYNC_W-1:0]  rawBundle;
  logic               tckS;
  logic               tdiS;
  logic               tckRise;
  logic               tckFall;
  logic [NUM_LANES-1:0] dirS;
  logic [NUM_LANES-1:0] enNS;
  logic [PIN_W-1:0]   aS;
  logic [PIN_W-1:0]   bS;
  logic [NUM_LANES-1:0] aSideDriveEnable;
  logic [NUM_LANES-1:0] bSideDriveEnable;
  logic [BSR_W-1:0]   captureVec;
  logic [PIN_W-1:0]   effAOut;
  logic [PIN_W-1:0]   effAOeN;
  logic [PIN_W-1:0]   effBOut;
  logic [PIN_W-1:0]   effBOeN;
  logic               selBoundary;
  logic               forceCells;
  logic               floatAll;
  logic               systemMode;

  tap_fsm u_tap_fsm (
    .mclk (mclk),
    .nrst (nrst),
    .tap  (tap.fsm)
  );

  // Every pin enters the same two-stage bundle so TMS/TDI stay aligned with TCK
  assign rawBundle = {laneTwoPortBIn, laneOnePortBIn, laneTwoPortAIn, laneOnePortAIn,
                      laneTwoOutputEnableN, laneOneOutputEnableN,
                      laneTwoDirectionSelect, laneOneDirectionSelect, tdi, tms, tck};

  assign tckS = r.sync2[SY_TCK];
  assign tdiS = r.sync2[SY_TDI];
  assign dirS = r.sync2[SY_DIR +: NUM_LANES];
  assign enNS = r.sync2[SY_ENN +: NUM_LANES];
  assign aS   = r.sync2[SY_A +: PIN_W];
  assign bS   = r.sync2[SY_B +: PIN_W];

  assign tckRise = tckS & ~r.tckPrev;
  assign tckFall = ~tckS & r.tckPrev;

  assign tap.tckRise = tckRise;
  assign tap.tms     = r.sync2[SY_TMS];

  assign selBoundary = (r.irActive == IR_EXTEST) || (r.irActive == IR_SAMPLE);
  assign forceCells  = (r.irActive == IR_EXTEST) || (r.irActive == IR_CLAMP);
  assign floatAll    = (r.irActive == IR_HIGHZ);
  assign systemMode  = !forceCells && !floatAll;

  genvar l;
  generate
    for (l = 0; l < NUM_LANES; l++)
    begin : g_lane
      // one A and one B enable per lane
      assign aSideDriveEnable[l] = ~enNS[l] & ~dirS[l];
      assign bSideDriveEnable[l] = ~enNS[l] & dirS[l];
      assign captureVec[BIT_DIR - CTRL_STRIDE*l] = dirS[l];
      assign captureVec[BIT_ENN - CTRL_STRIDE*l] = enNS[l];
      assign captureVec[BIT_AOE - CTRL_STRIDE*l] = aSideDriveEnable[l];
      assign captureVec[BIT_BOE - CTRL_STRIDE*l] = bSideDriveEnable[l];
    end
  endgenerate

  genvar i;
  generate
    for (i = 0; i < PIN_W; i++)
    begin : g_pin
      localparam int LN = i / LANE_W;
      // observe-only cells, A-in and B-in groups
      assign captureVec[BIT_AIN_TOP - i]  = aS[i];
      assign captureVec[BIT_BIN_TOP - i]  = bS[i];
      // output cells capture the system value
      assign captureVec[BIT_BOUT_TOP - i] = aS[i];
      assign captureVec[BIT_AOUT_TOP - i] = bS[i];
      assign effAOut[i] = forceCells ? r.bsrUpd[BIT_AOUT_TOP - i] : bS[i];
      assign effBOut[i] = forceCells ? r.bsrUpd[BIT_BOUT_TOP - i] : aS[i];
      assign effAOeN[i] = floatAll ? 1'b1 :
                          forceCells ? ~r.bsrUpd[BIT_AOE - CTRL_STRIDE*LN] : ~aSideDriveEnable[LN];
      assign effBOeN[i] = floatAll ? 1'b1 :
                          forceCells ? ~r.bsrUpd[BIT_BOE - CTRL_STRIDE*LN] : ~bSideDriveEnable[LN];
    end
  endgenerate

  always_comb
  begin
    n         = r;
    n.sync1   = rawBundle;
    n.sync2   = r.sync1;
    n.tckPrev = tckS;
    n.aOut    = effAOut;
    n.aOeN    = effAOeN;
    n.bOut    = effBOut;
    n.bOeN    = effBOeN;

    if (tckRise)
    begin
      if (tap.state == TAP_CAP_IR)
      begin
        n.irShift = {IR_CAPTURE_HI, IR_CAPTURE_LSB};
      end
      else if (tap.state == TAP_SHIFT_IR)
      begin
        n.irShift = {tdiS, r.irShift[IR_W-1:1]};
      end
      else if (tap.state == TAP_CAP_DR)
      begin
        if (selBoundary)
        begin
          n.bsrShift = captureVec;
        end
        else
        begin
          n.bypass = 1'b0;
        end
      end
      else if (tap.state == TAP_SHIFT_DR)
      begin
        if (selBoundary)
        begin
          n.bsrShift = {tdiS, r.bsrShift[BSR_W-1:1]};
        end
        else
        begin
          n.bypass = tdiS;
        end
      end
    end

    // Falling-edge actions keep TDO and update latches clear of the rising capture
    if (tckFall)
    begin
      if (tap.state == TAP_SHIFT_IR)
      begin
        n.tdo    = r.irShift[0];
        n.tdoOeN = 1'b0;
      end
      else if (tap.state == TAP_SHIFT_DR)
      begin
        n.tdo    = selBoundary ? r.bsrShift[0] : r.bypass;
        n.tdoOeN = 1'b0;
      end
      else
      begin
        n.tdoOeN = 1'b1;
      end
      if (tap.state == TAP_UPD_IR)
      begin
        n.irActive = r.irShift;
      end
      if (tap.state == TAP_UPD_DR && selBoundary)
      begin
        n.bsrUpd = r.bsrShift;
      end
    end

    if (tap.state == TAP_RESET)
    begin
      n.irActive = IR_RESET_CODE;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      r <= CORE_RST;
    end
    else
    begin
      r <= n;
    end
  end

  assign laneOnePortAOut = r.aOut[LANE_W-1:0];
  assign laneTwoPortAOut = r.aOut[PIN_W-1:LANE_W];
  assign laneOnePortAOeN = r.aOeN[LANE_W-1:0];
  assign laneTwoPortAOeN = r.aOeN[PIN_W-1:LANE_W];
  assign laneOnePortBOut = r.bOut[LANE_W-1:0];
  assign laneTwoPortBOut = r.bOut[PIN_W-1:LANE_W];
  assign laneOnePortBOeN = r.bOeN[LANE_W-1:0];
  assign laneTwoPortBOeN = r.bOeN[PIN_W-1:LANE_W];
  assign tdo             = r.tdo;
  assign tdoOeN          = r.tdoOeN;

  AST_B_TO_A: assert property (@(posedge mclk) disable iff (!nrst)
    ($past(nrst) && $past(systemMode) && !$past(enNS[0]) && !$past(dirS[0]))
    |-> (r.aOut[LANE_W-1:0] == $past(bS[LANE_W-1:0]) && r.aOeN[LANE_W-1:0] == 9'h000
         && r.bOeN[LANE_W-1:0] == 9'h1FF))
    else $error("lane one B to A path wrong");

  AST_A_TO_B: assert property (@(posedge mclk) disable iff (!nrst)
    ($past(nrst) && $past(systemMode) && !$past(enNS[1]) && $past(dirS[1]))
    |-> (r.bOut[PIN_W-1:LANE_W] == $past(aS[PIN_W-1:LANE_W]) && r.bOeN[PIN_W-1:LANE_W] == 9'h000
         && r.aOeN[PIN_W-1:LANE_W] == 9'h1FF))
    else $error("lane two A to B path wrong");

  AST_ENABLE_FLOAT: assert property (@(posedge mclk) disable iff (!nrst)
    ($past(nrst) && $past(systemMode) && $past(enNS[0]))
    |-> (r.aOeN[LANE_W-1:0] == 9'h1FF && r.bOeN[LANE_W-1:0] == 9'h1FF))
    else $error("disabled lane still drives");

  AST_HIGHZ_ALL: assert property (@(posedge mclk) disable iff (!nrst)
    ($past(nrst) && $past(floatAll)) |-> (&r.aOeN && &r.bOeN))
    else $error("outputs driven under HIGHZ");

  AST_CELL_OVERRIDE: assert property (@(posedge mclk) disable iff (!nrst)
    ($past(nrst) && $past(forceCells))
    |-> (r.aOut[0] == $past(r.bsrUpd[BIT_AOUT_TOP]) && r.bOut[PIN_W-1] == $past(r.bsrUpd[BIT_BIN_TOP + 1])))
    else $error("output cell does not override the pin");

  AST_ENABLE_CELL: assert property (@(posedge mclk) disable iff (!nrst)
    ($past(nrst) && $past(forceCells))
    |-> (r.aOeN[0] == !$past(r.bsrUpd[BIT_AOE]) && r.bOeN[LANE_W] == !$past(r.bsrUpd[BIT_BOE - CTRL_STRIDE])))
    else $error("enable cell does not govern outputs");

  AST_BYPASS_ZERO: assert property (@(posedge mclk) disable iff (!nrst)
    (tckRise && tap.state == TAP_CAP_DR && !selBoundary) |=> (r.bypass == 1'b0))
    else $error("bypass did not capture zero");

  AST_IR_CAPTURE: assert property (@(posedge mclk) disable iff (!nrst)
    (tckRise && tap.state == TAP_CAP_IR) |=> (r.irShift == {IR_CAPTURE_HI, IR_CAPTURE_LSB}))
    else $error("instruction capture value wrong");

  AST_DECODE: assert property (@(posedge mclk) disable iff (!nrst)
    (r.irActive == IR_SAMPLE) |-> (selBoundary && systemMode))
    else $error("SAMPLE decode wrong");

  AST_BSR_SHIFT: assert property (@(posedge mclk) disable iff (!nrst)
    (tckRise && tap.state == TAP_SHIFT_DR && selBoundary)
    |=> (r.bsrShift == {$past(tdiS), $past(r.bsrShift[BSR_W-1:1])}))
    else $error("boundary shift wrong");

  AST_CAPTURE_MAP: assert property (@(posedge mclk) disable iff (!nrst)
    (tckRise && tap.state == TAP_CAP_DR && selBoundary)
    |=> (r.bsrShift[BIT_DIR] == $past(dirS[0]) && r.bsrShift[BIT_AIN_TOP] == $past(aS[0])
         && r.bsrShift[BIT_BIN_TOP] == $past(bS[0]) && r.bsrShift[BIT_ENN - CTRL_STRIDE] == $past(enNS[1])))
    else $error("boundary capture map wrong");

  AST_TDO_FALL: assert property (@(posedge mclk) disable iff (!nrst)
    (tckFall && tap.state == TAP_SHIFT_IR) |=> (!r.tdoOeN && r.tdo == $past(r.irShift[0])))
    else $error("TDO not presented on falling edge");

endmodule

// [verif/test_ctrl_model.sv]
// Purpose: Behavioural test controller driving the scan port from outside
// Assumes: Each call starts on a falling mclk edge; 64 ns test clock
// Notes:   Test clock stands still between frames; TDI idles high
`timescale 1ns/1ps
module test_ctrl_model (
  // Test access lines
  output logic tck,
  output logic tms,
  output logic tdi,
  input  logic tdo
);
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #32;
    q = tdo;
    tck = 1'b1;
    #32;
    tck = 1'b0;
  endtask

  task automatic reset_tap;
    logic q;
    repeat (5) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask

  // Idle to capture, shift n bits LSB first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [79:0] din, output logic [79:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b1, q);
    if (ir)
      step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int k = 0; k < n; k++)
    begin
      step(k == n - 1, din[k], q);
      dout[k] = q;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    tdi = 1'b1;
  endtask
endmodule

// [verif/dual_byte_transceiver_boundary_scan_test.sv]
// Purpose: Self-checking bench for the dual-lane transceiver with boundary scan
// Assumes: Outputs settle within 6 mclk of a pin change
// Notes:   Bench resolves each pin from the device enable and its own drive
`timescale 1ns/1ps
module dual_byte_transceiver_boundary_scan_test
  import bscan_pkg::*;
;
  logic        mclk;
  logic        nrst;
  logic        lane_one_direction_select;
  logic        en1N;
  logic        lane_two_direction_select;
  logic        en2N;
  logic [17:0] aDrv;
  logic [17:0] bDrv;
  wire  [17:0] aOut;
  wire  [17:0] aOeN;
  wire  [17:0] bOut;
  wire  [17:0] bOeN;
  wire  [17:0] aIn;
  wire  [17:0] bIn;
  wire         tck;
  wire         tms;
  wire         tdi;
  wire         tdo;
  wire         tdoOeN;
  int          bad_count = 0;
  int          checks = 0;
  int          cycles = 0;
  logic [79:0] dout;

  // Device drive wins where its enable is low
  assign aIn = (aOut & ~aOeN) | (aDrv & aOeN);
  assign bIn = (bOut & ~bOeN) | (bDrv & bOeN);

  dual_byte_transceiver_boundary_scan u_dual_byte_transceiver_boundary_scan (
    .mclk                   (mclk),
    .nrst                   (nrst),
    .laneOneDirectionSelect (lane_one_direction_select),
    .laneOneOutputEnableN   (en1N),
    .laneTwoDirectionSelect (lane_two_direction_select),
    .laneTwoOutputEnableN   (en2N),
    .laneOnePortAIn         (aIn[8:0]),
    .laneOnePortAOut        (aOut[8:0]),
    .laneOnePortAOeN        (aOeN[8:0]),
    .laneOnePortBIn         (bIn[8:0]),
    .laneOnePortBOut        (bOut[8:0]),
    .laneOnePortBOeN        (bOeN[8:0]),
    .laneTwoPortAIn         (aIn[17:9]),
    .laneTwoPortAOut        (aOut[17:9]),
    .laneTwoPortAOeN        (aOeN[17:9]),
    .laneTwoPortBIn         (bIn[17:9]),
    .laneTwoPortBOut        (bOut[17:9]),
    .laneTwoPortBOeN        (bOeN[17:9]),
    .tck                    (tck),
    .tms                    (tms),
    .tdi                    (tdi),
    .tdo                    (tdo),
    .tdoOeN                 (tdoOeN)
  );

  // Released TDO line is pulled high
  test_ctrl_model u_test_ctrl_model (
    .tck (tck),
    .tms (tms),
    .tdi (tdi),
    .tdo (tdoOeN ? 1'b1 : tdo)
  );

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      bad_count++;
      print_verdict;
    end
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string n, input logic [79:0] s, input logic [79:0] e);
    checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  function automatic logic [79:0] place(input logic [17:0] v, input int top);
    logic [79:0] r;
    r = '0;
    for (int i = 0; i < PIN_W; i++)
      r[top - i] = v[i];
    return r;
  endfunction

  // Controls as {lane_one_direction_select, en1N, lane_two_direction_select, en2N}
  task automatic pins(input logic [3:0] c, input logic [17:0] a, input logic [17:0] b);
    @(negedge mclk);
    {lane_one_direction_select, en1N, lane_two_direction_select, en2N} = c;
    aDrv = a;
    bDrv = b;
    repeat (6) @(negedge mclk);
  endtask

  task automatic set_ir(input logic [7:0] code);
    u_test_ctrl_model.scan(1'b1, 8, {72'h0, code}, dout);
    repeat (2) @(negedge mclk);
  endtask

  task automatic byp(input string n);
    u_test_ctrl_model.scan(1'b0, 2, 80'h3, dout);
    chk(n, dout[1:0], 2'b10);
  endtask

  task automatic t_reset;
    chk("aOeN", aOeN, 18'h3FFFF);
    chk("bOeN", bOeN, 18'h3FFFF);
    chk("tdoOeN", tdoOeN, 1'b1);
    $display("test reset done");
  endtask

  task automatic t_path;
    pins(4'b0010, {9'h0A5, 9'h13B}, {9'h0C6, 9'h15A});
    chk("aOut1", aOut[8:0], 9'h15A);
    chk("aOeN", aOeN, {9'h1FF, 9'h000});
    chk("bOut2", bOut[17:9], 9'h0A5);
    chk("bOeN", bOeN, {9'h000, 9'h1FF});
    pins(4'b1000, {9'h0A5, 9'h13B}, {9'h0C6, 9'h15A});
    chk("bOut1", bOut[8:0], 9'h13B);
    chk("aOut2", aOut[17:9], 9'h0C6);
    pins(4'b0110, {9'h0A5, 9'h13B}, {9'h0C6, 9'h15A});
    chk("aOeN", aOeN, 18'h3FFFF);
    chk("bOeN", bOeN, {9'h000, 9'h1FF});
    $display("test path done");
  endtask

  task automatic t_ircap;
    u_test_ctrl_model.reset_tap;
    byp("resetDr");
    u_test_ctrl_model.scan(1'b1, 8, 80'hFF, dout);
    chk("irCapture", dout[7:0], {IR_CAPTURE_HI_DEF, 2'b01});
    chk("tdoOeN", tdoOeN, 1'b1);
    $display("test ircap done");
  endtask

  task automatic t_bypass;
    logic [7:0] codes [4] = '{8'hFF, 8'h5A, 8'h01, 8'h80};
    for (int k = 0; k < 4; k++)
    begin
      set_ir(codes[k]);
      byp("bypass");
    end
    $display("test bypass done");
  endtask

  task automatic t_sample;
    logic [79:0] exp;
    logic [79:0] pre;
    pins(4'b0011, {9'h0F3, 9'h000}, {9'h0AA, 9'h155});
    exp = place({9'h0F3, 9'h155}, 71) | place({9'h0F3, 9'h155}, 53) | {8'h2C, 72'h0};
    exp = exp | place({9'h0AA, 9'h155}, 35) | place({9'h0AA, 9'h155}, 17);
    pre = place({9'h13C, 9'h000}, 53) | place({9'h000, 9'h0C3}, 17) | {8'h21, 72'h0};
    set_ir(IR_SAMPLE);
    u_test_ctrl_model.scan(1'b0, 80, pre, dout);
    chk("sample", dout, exp);
    set_ir(IR_EXTEST);
    chk("extA1", aOut[8:0], 9'h0C3);
    chk("extAoe", aOeN, {9'h1FF, 9'h000});
    chk("extB2", bOut[17:9], 9'h13C);
    chk("extBoe", bOeN, {9'h000, 9'h1FF});
    $display("test sample done");
  endtask

  task automatic t_clamp;
    set_ir(IR_CLAMP);
    chk("clampA1", aOut[8:0], 9'h0C3);
    chk("clampBoe", bOeN, {9'h000, 9'h1FF});
    byp("clampByp");
    set_ir(IR_HIGHZ);
    chk("hzA", aOeN, 18'h3FFFF);
    chk("hzB", bOeN, 18'h3FFFF);
    byp("hzByp");
    u_test_ctrl_model.reset_tap;
    repeat (2) @(negedge mclk);
    chk("sysA1", aOut[8:0], 9'h155);
    chk("sysAoe", aOeN, {9'h1FF, 9'h000});
    $display("test clamp done");
  endtask

  initial
  begin
    nrst = 1'b0;
    lane_one_direction_select = 1'b0;
    en1N = 1'b1;
    lane_two_direction_select = 1'b0;
    en2N = 1'b1;
    aDrv = 18'h00000;
    bDrv = 18'h00000;
    repeat (12) @(negedge mclk);
    nrst = 1'b1;
    repeat (4) @(negedge mclk);
    t_reset;
    t_path;
    t_ircap;
    t_bypass;
    t_sample;
    t_clamp;
    print_verdict;
  end
endmodule
